// ### design/swm_sleep_wake.sv
// Sleep/wake manager with AHB-Lite configuration registers
`timescale 1ns/1ns

module swm_sleep_wake
  import swm_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = HALF_WAIT_CYCLES,
  parameter int unsigned UNIT_CYCLES = SLEEP_UNIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic low_power_strap_in,
  input wire logic reserved_mode_strap_in,
  input wire logic [7:0] watch_pins_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_cmd_in,
  input wire logic tx_done_in,
  output logic tx_valid_out,
  output swm_pkt_t tx_pkt_out,
  output logic antenna_select_a_out,
  output logic antenna_select_b_out,
  output logic low_power_out,
  output logic reserved_mode_out
);

  localparam int unsigned HW = $clog2(HALF_CYCLES + 1);

  swm_state_t state;
  swm_state_t next_state;
  logic [7:0] sleep_hi;
  logic [7:0] sleep_lo;
  logic [7:0] wait_count;
  logic [7:0] watch_mask;
  logic [7:0] pin_input;
  logic [7:0] pin_snap;
  logic [7:0] last_change;
  logic [7:0] tries_left;
  logic [HW-1:0] half_cnt;
  logic half_done;
  logic timer_exp;
  logic [7:0] changes;
  logic pin_wake;
  logic go_sleep;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic bus_take;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] masked_changes(
    input logic [7:0] pins,
    input logic [7:0] snap,
    input logic [7:0] mask,
    input logic [7:0] dir
  );
    masked_changes = (pins ^ snap) & mask & dir;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] idx);
    case (idx)
      IDX_SLEEP_HI: read_word = {24'h000000, sleep_hi};
      IDX_SLEEP_LO: read_word = {24'h000000, sleep_lo};
      IDX_WAIT_COUNT: read_word = {24'h000000, wait_count};
      IDX_WATCH_MASK: read_word = {24'h000000, watch_mask};
      IDX_PIN_INPUT: read_word = {24'h000000, pin_input};
      IDX_STATUS: read_word = {8'h00, last_change, pin_snap, 3'h0,
        low_power_out, reserved_mode_out, state};
      default: read_word = 32'h00000000;
    endcase
  endfunction

  assign changes = masked_changes(watch_pins_in, pin_snap, watch_mask,
    pin_input);
  assign pin_wake = |changes;
  assign go_sleep = rx_valid_in && (rx_cmd_in == CMD_GO_SLEEP);
  assign half_done = (half_cnt == HW'(HALF_CYCLES - 1));
  assign bus_take = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);

  // ==========================================================
  // AHB-Lite slave, zero wait, always OKAY
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      wr_pend <= bus_take && hwrite_in;
      wr_idx <= haddr_in[ADDR_LSB +: 8];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hrdata_out <= 32'h00000000;
    end else if (bus_take && !hwrite_in) begin
      hrdata_out <= read_word(haddr_in[ADDR_LSB +: 8]);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sleep_hi <= RST_SLEEP_HI;
      sleep_lo <= RST_SLEEP_LO;
      wait_count <= RST_WAIT_COUNT;
      watch_mask <= RST_WATCH_MASK;
      pin_input <= RST_PIN_INPUT;
    end else if (wr_pend) begin
      case (wr_idx)
        IDX_SLEEP_HI: sleep_hi <= hwdata_in[7:0];
        IDX_SLEEP_LO: sleep_lo <= hwdata_in[7:0];
        IDX_WAIT_COUNT: wait_count <= hwdata_in[7:0];
        IDX_WATCH_MASK: watch_mask <= hwdata_in[7:0];
        IDX_PIN_INPUT: pin_input <= hwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Sleep span timer
  swm_sleep_timer #(
    .TICK_CYCLES(UNIT_CYCLES),
    .SW(16)
  ) u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(state == ST_SLEEP),
    .span_in({sleep_hi, sleep_lo}),
    .expired_out(timer_exp)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_BOOT: begin
        next_state = low_power_strap_in ? ST_IDLE : ST_SLEEP;
      end
      ST_IDLE: begin
        if (go_sleep) begin
          next_state = ST_SLEEP;
        end else if (pin_wake) begin
          next_state = ST_SEND;
        end
      end
      ST_SLEEP: begin
        if (pin_wake || timer_exp) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_done_in) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (go_sleep) begin
          next_state = ST_SLEEP;
        end else if (rx_valid_in) begin
          next_state = ST_AWAKE;
        end else if (half_done) begin
          next_state = (tries_left <= 8'h01) ? ST_SLEEP : ST_SEND;
        end
      end
      ST_AWAKE: begin
        if (go_sleep) begin
          next_state = ST_SLEEP;
        end
      end
      default: next_state = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Straps and pin snapshot
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reserved_mode_out <= 1'b0;
    end else if (state == ST_BOOT) begin
      reserved_mode_out <= !reserved_mode_strap_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_snap <= 8'h00;
      last_change <= 8'h00;
    end else if (state == ST_BOOT) begin
      pin_snap <= watch_pins_in;
    end else if ((state == ST_IDLE || state == ST_SLEEP) && pin_wake) begin
      pin_snap <= watch_pins_in;
      last_change <= changes;
    end
  end

  // ==========================================================
  // Half-second waits and tries
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      half_cnt <= '0;
    end else if (state != ST_WAIT || half_done) begin
      half_cnt <= '0;
    end else begin
      half_cnt <= half_cnt + HW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tries_left <= 8'h00;
    end else if ((state == ST_IDLE || state == ST_SLEEP) &&
                 next_state == ST_SEND) begin
      tries_left <= wait_count;
    end else if (state == ST_WAIT && next_state == ST_SEND) begin
      tries_left <= tries_left - 8'h01;
    end
  end

  // ==========================================================
  // Outgoing check-in packet
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_pkt_out <= '0;
    end else if ((state == ST_IDLE || state == ST_SLEEP) &&
                 next_state == ST_SEND) begin
      tx_pkt_out.cmd <= pin_wake ? CMD_PIN_CHECKIN
                                 : CMD_WAKE_CHECKIN;
      tx_pkt_out.src_id <= BROADCAST_ID;
      tx_pkt_out.dst_id <= BROADCAST_ID;
      tx_pkt_out.pin_state <= watch_pins_in;
      tx_pkt_out.pin_change <= changes;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_valid_out <= 1'b0;
      low_power_out <= 1'b0;
    end else begin
      tx_valid_out <= (next_state == ST_SEND);
      low_power_out <= (next_state == ST_SLEEP);
    end
  end

  // ==========================================================
  // Antenna switch
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      antenna_select_a_out <= 1'b1;
      antenna_select_b_out <= 1'b0;
    end else begin
      antenna_select_a_out <= (next_state != ST_SEND);
      antenna_select_b_out <= (next_state == ST_SEND);
    end
  end

  // ==========================================================
  // Checks
  a_ant_tx_levels: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    tx_valid_out |-> !antenna_select_a_out && antenna_select_b_out)
    else $error("antenna not in transmit setting");

  a_ant_rx_levels: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state == ST_WAIT |-> antenna_select_a_out && !antenna_select_b_out)
    else $error("antenna not in receive setting");

  a_strap_sleep: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state == ST_BOOT && !low_power_strap_in
      |=> state == ST_SLEEP && low_power_out && pin_snap == $past(watch_pins_in))
    else $error("low-power strap did not start sleep");

  a_pin_wake_pkt: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state == ST_SLEEP && pin_wake
      |=> tx_valid_out && tx_pkt_out.cmd == CMD_PIN_CHECKIN &&
          tx_pkt_out.src_id == BROADCAST_ID)
    else $error("pin change did not send check-in");

  a_mask_gate: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state == ST_IDLE && ((watch_pins_in ^ pin_snap) & watch_mask) == 8'h00
      && !go_sleep |=> state == ST_IDLE)
    else $error("unmasked pin caused wake");

  a_timer_wake_pkt: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state == ST_SLEEP && timer_exp && !pin_wake
      |=> tx_valid_out && tx_pkt_out.cmd == CMD_WAKE_CHECKIN &&
          tx_pkt_out.dst_id == BROADCAST_ID)
    else $error("timer expiry did not send wake packet");

  a_give_up: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state == ST_WAIT && half_done && !rx_valid_in && tries_left <= 8'h01
      |=> state == ST_SLEEP && low_power_out)
    else $error("no return to sleep after last wait");

  a_retry_send: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state == ST_WAIT && half_done && !rx_valid_in && tries_left > 8'h01
      |=> tx_valid_out && tries_left == $past(tries_left) - 8'h01)
    else $error("retry not sent after half second");

  a_sleep_cmd: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    (state == ST_WAIT || state == ST_AWAKE) && go_sleep
      |=> state == ST_SLEEP && low_power_out)
    else $error("sleep code not obeyed");

  a_reserved_latch: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state == ST_BOOT |=> reserved_mode_out == !$past(reserved_mode_strap_in))
    else $error("reserved strap not captured");

  c_pin_wake: cover property (@(posedge clk_in) disable iff (!resetn_in)
    state == ST_SLEEP && pin_wake);
  c_timer_wake: cover property (@(posedge clk_in) disable iff (!resetn_in)
    state == ST_SLEEP && timer_exp);
  c_reply_awake: cover property (@(posedge clk_in) disable iff (!resetn_in)
    state == ST_WAIT ##1 state == ST_AWAKE);
  c_give_up: cover property (@(posedge clk_in) disable iff (!resetn_in)
    state == ST_WAIT ##1 state == ST_SLEEP);

endmodule

// ### design/swm_pkg.sv
// Shared constants and types for the sleep/wake manager
package swm_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SLEEP_UNIT_S = 5;
  localparam int unsigned HALF_WAIT_MS = 500;
  localparam int unsigned SLEEP_UNIT_CYCLES = SLEEP_UNIT_S * CLK_HZ;
  localparam int unsigned HALF_WAIT_CYCLES = HALF_WAIT_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Register map, byte address = four times config byte index
  localparam logic [7:0] IDX_SLEEP_HI = 8'h04;
  localparam logic [7:0] IDX_SLEEP_LO = 8'h05;
  localparam logic [7:0] IDX_WAIT_COUNT = 8'h06;
  localparam logic [7:0] IDX_WATCH_MASK = 8'h08;
  localparam logic [7:0] IDX_PIN_INPUT = 8'h09;
  localparam logic [7:0] IDX_STATUS = 8'h0A;
  localparam int unsigned ADDR_LSB = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_SLEEP_HI = 8'h00;
  localparam logic [7:0] RST_SLEEP_LO = 8'h01;
  localparam logic [7:0] RST_WAIT_COUNT = 8'h02;
  localparam logic [7:0] RST_WATCH_MASK = 8'h00;
  localparam logic [7:0] RST_PIN_INPUT = 8'hFF;

  // ==========================================================
  // Packet codes
  localparam logic [7:0] CMD_PIN_CHECKIN = 8'hC1;
  localparam logic [7:0] CMD_WAKE_CHECKIN = 8'hC2;
  localparam logic [7:0] CMD_GO_SLEEP = 8'hA4;
  localparam logic [15:0] BROADCAST_ID = 16'h0000;

  // ==========================================================
  // Bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_IDLE = 3'h1,
    ST_SLEEP = 3'h2,
    ST_SEND = 3'h3,
    ST_WAIT = 3'h4,
    ST_AWAKE = 3'h5
  } swm_state_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] src_id;
    logic [15:0] dst_id;
    logic [7:0] pin_state;
    logic [7:0] pin_change;
  } swm_pkt_t;

endpackage

// ### design/swm_sleep_timer.sv
// Free-running low-power tick and sleep span counter
`timescale 1ns/1ns
module swm_sleep_timer
  import swm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SLEEP_UNIT_CYCLES,
  parameter int unsigned SW = 16
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic [SW-1:0] span_in,
  output logic expired_out
);

  localparam int unsigned PW = $clog2(TICK_CYCLES + 1);

  logic [PW-1:0] pre_cnt;
  logic [SW-1:0] unit_cnt;
  logic tick;
  logic [SW:0] eff_span;

  assign tick = (pre_cnt == PW'(TICK_CYCLES - 1));
  assign eff_span = (span_in == '0) ? (SW+1)'(1) : {1'b0, span_in};

  // ==========================================================
  // Prescaler, never stopped
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_cnt <= '0;
    end else if (tick) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + PW'(1);
    end
  end

  // ==========================================================
  // Span counter
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      unit_cnt <= '0;
    end else if (!run_in) begin
      unit_cnt <= '0;
    end else if (tick) begin
      unit_cnt <= unit_cnt + SW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      expired_out <= 1'b0;
    end else begin
      expired_out <= run_in && tick &&
        (({1'b0, unit_cnt} + (SW+1)'(1)) >= eff_span);
    end
  end

  // ==========================================================
  // Checks
  a_expire_on_tick: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    expired_out |-> $past(run_in) && $past(tick))
    else $error("sleep expiry without a tick");

  a_expire_span: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    run_in && tick && ({1'b0, unit_cnt} + (SW+1)'(1) < eff_span)
      |=> !expired_out)
    else $error("sleep expiry before span reached");

endmodule

// ### verif/swm_remote_ctrl.sv
// Remote controller model answering check-in packets
`timescale 1ns/1ns
module swm_remote_ctrl
  import swm_pkg::*;
#(
  parameter int unsigned DONE_DELAY = 3,
  parameter int unsigned REPLY_WAIT = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic tx_valid_in,
  input wire logic [1:0] mode_in,
  output logic tx_done_out,
  output logic rx_valid_out,
  output logic [7:0] rx_cmd_out
);
  logic [7:0] done_cnt;
  logic [7:0] reply_cnt;
  logic [1:0] phase;
  // ==========================================================
  // Radio send completion
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_cnt <= 8'h00;
      tx_done_out <= 1'b0;
    end else if (tx_done_out || !tx_valid_in) begin
      done_cnt <= 8'h00;
      tx_done_out <= 1'b0;
    end else begin
      done_cnt <= done_cnt + 8'h01;
      tx_done_out <= (done_cnt == 8'(DONE_DELAY - 1));
    end
  end
  // ==========================================================
  // Replies: none, sleep code, or a data read then sleep code
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reply_cnt <= 8'h00;
      phase <= 2'h0;
      rx_valid_out <= 1'b0;
      rx_cmd_out <= 8'h00;
    end else begin
      rx_valid_out <= 1'b0;
      rx_cmd_out <= ~rx_cmd_out;
      if (tx_done_out) begin
        reply_cnt <= 8'(REPLY_WAIT);
        phase <= mode_in;
      end else if (reply_cnt != 8'h00) begin
        reply_cnt <= reply_cnt - 8'h01;
        if (reply_cnt == 8'h01 && phase != 2'h0) begin
          rx_valid_out <= 1'b1;
          rx_cmd_out <= (phase == 2'h2) ? 8'hAA : CMD_GO_SLEEP;
          phase <= 2'h1;
          if (phase == 2'h2) begin
            reply_cnt <= 8'(REPLY_WAIT * 8);
          end
        end
      end
    end
  end
endmodule

// ### verif/tb.sv
// Bench for the sleep/wake manager with a remote controller model
`timescale 1ns/1ns
module tb;
  import swm_pkg::*;
  localparam int unsigned HALF = 20;
  localparam int unsigned UNIT = 16;
  localparam int LIMIT = 20000;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic hreadyout, hresp, rx_valid, tx_done, tx_valid;
  logic lp_strap = 1'b0, res_strap = 1'b1, tx_prev = 1'b0;
  logic [7:0] pins = 8'h5A, rx_cmd;
  logic ant_a, ant_b, low_power, res_mode;
  logic [1:0] mode = 2'h1;
  swm_pkt_t pkt;
  int pkts = 0, cycles = 0, miscompares = 0, check_count = 0;
  int n, p0, t0;

  swm_sleep_wake #(
    .HALF_CYCLES(HALF),
    .UNIT_CYCLES(UNIT)
  ) i_swm_sleep_wake (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp),
    .low_power_strap_in(lp_strap), .reserved_mode_strap_in(res_strap),
    .watch_pins_in(pins), .rx_valid_in(rx_valid), .rx_cmd_in(rx_cmd),
    .tx_done_in(tx_done), .tx_valid_out(tx_valid), .tx_pkt_out(pkt),
    .antenna_select_a_out(ant_a), .antenna_select_b_out(ant_b),
    .low_power_out(low_power), .reserved_mode_out(res_mode)
  );

  swm_remote_ctrl i_swm_remote_ctrl (
    .clk_in(clk_in), .resetn_in(resetn_in), .tx_valid_in(tx_valid),
    .mode_in(mode), .tx_done_out(tx_done), .rx_valid_out(rx_valid),
    .rx_cmd_out(rx_cmd)
  );

  // ==========================================================
  // Clock, packet monitor and timeout
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    tx_prev <= tx_valid;
    if (tx_valid === 1'b1 && tx_prev !== 1'b1) pkts <= pkts + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  // ==========================================================
  // Tasks
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge clk_in);
    while (hreadyout !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_in);
    while (hreadyout !== 1'b1) @(posedge clk_in);
    r = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(r, exp);
    check(32'(hresp), 32'(HRESP_OKAY));
  endtask
  task automatic wait_for(input bit want_tx, input int max);
    n = 0;
    @(negedge clk_in);
    while ((want_tx ? tx_valid : low_power) !== 1'b1) begin
      @(negedge clk_in);
      n++;
      if (n > max) begin
        miscompares++;
        $display("BAD %0t wait ran out", $time);
        return;
      end
    end
  endtask
  task automatic check_pkt(input logic [7:0] cmd, input logic [7:0] chg);
    check(32'(pkt.cmd), 32'(cmd));
    check(32'(pkt.src_id), 32'(BROADCAST_ID));
    check(32'(pkt.dst_id), 32'(BROADCAST_ID));
    check(32'(pkt.pin_state), 32'(pins));
    check(32'(pkt.pin_change), 32'(chg));
    check(32'({ant_a, ant_b}), 32'h1);
  endtask
  task automatic do_reset(input logic lp, input logic res);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    lp_strap <= lp;
    res_strap <= res;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
  endtask
  task automatic flip(input logic [7:0] m);
    @(posedge clk_in);
    pins <= pins ^ m;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    do_reset(1'b0, 1'b1);
    repeat (3) @(negedge clk_in);
    check(32'({ant_a, ant_b, low_power, res_mode}), 32'hA);
    wait_for(1'b1, 2 * UNIT + 4);
    check_pkt(CMD_WAKE_CHECKIN, 8'h00);
    wait_for(1'b0, 60);
    check(32'({ant_a, ant_b, low_power}), 32'h5);
    bus(1'b1, IDX_SLEEP_HI, 32'hFF);
    repeat (60) @(posedge clk_in);
    wait_for(1'b0, 100);
    rd_chk(IDX_SLEEP_HI, 32'hFF);
    rd_chk(IDX_SLEEP_LO, 32'(RST_SLEEP_LO));
    rd_chk(IDX_WAIT_COUNT, 32'(RST_WAIT_COUNT));
    rd_chk(IDX_WATCH_MASK, 32'(RST_WATCH_MASK));
    rd_chk(IDX_PIN_INPUT, 32'(RST_PIN_INPUT));
    rd_chk(8'h0F, 32'h0);
    bus(1'b0, IDX_STATUS, 32'h0);
    check(32'({r[15:8], r[4:0]}), 32'({pins, 5'h12}));
    bus(1'b1, IDX_WATCH_MASK, 32'h80);
    bus(1'b1, IDX_SLEEP_LO, 32'h02);
    rd_chk(IDX_WATCH_MASK, 32'h80);
    p0 = pkts;
    flip(8'h01);
    repeat (40) @(negedge clk_in);
    check(32'(pkts - p0), 32'h0);
    flip(8'h01);
    bus(1'b1, IDX_SLEEP_HI, 32'h01);
    flip(8'h80);
    wait_for(1'b1, 8);
    check_pkt(CMD_PIN_CHECKIN, 8'h80);
    wait_for(1'b0, 60);
    mode <= 2'h0;
    t0 = cycles;
    p0 = pkts;
    bus(1'b0, IDX_STATUS, 32'h0);
    check(32'(r[23:8]), 32'({8'h80, pins}));
    wait_for(1'b1, 258 * UNIT + 8);
    n = cycles - t0;
    check(32'(n >= 257 * UNIT && n <= 258 * UNIT + 4), 32'h1);
    check_pkt(CMD_WAKE_CHECKIN, 8'h00);
    t0 = cycles;
    wait_for(1'b0, 200);
    n = cycles - t0;
    check(32'(pkts - p0), 32'h2);
    check(32'(n >= 2 * HALF && n <= 2 * HALF + 16), 32'h1);
    mode <= 2'h2;
    flip(8'h80);
    wait_for(1'b1, 8);
    check_pkt(CMD_PIN_CHECKIN, 8'h80);
    repeat (30) @(negedge clk_in);
    bus(1'b0, IDX_STATUS, 32'h0);
    check(32'(r[4:0]), 32'h5);
    wait_for(1'b0, 100);
    check(32'(low_power), 32'h1);
    do_reset(1'b1, 1'b0);
    repeat (3) @(negedge clk_in);
    res_strap <= 1'b1;
    check(32'({low_power, res_mode}), 32'h1);
    bus(1'b0, IDX_STATUS, 32'h0);
    check(32'(r[4:0]), 32'h9);
    mode <= 2'h1;
    bus(1'b1, IDX_WATCH_MASK, 32'h01);
    bus(1'b1, IDX_PIN_INPUT, 32'hFE);
    p0 = pkts;
    flip(8'h01);
    repeat (20) @(negedge clk_in);
    check(32'(pkts - p0), 32'h0);
    flip(8'h01);
    bus(1'b1, IDX_PIN_INPUT, 32'hFF);
    flip(8'h01);
    wait_for(1'b1, 8);
    check_pkt(CMD_PIN_CHECKIN, 8'h01);
    wait_for(1'b0, 60);
    check(32'(low_power), 32'h1);
    complete_run();
  end
endmodule
